// ### core/rsz_defs.svh
// Register offsets, field positions and reset values of the resizer
// stride and coefficient register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef RSZ_DEFS_SVH
`define RSZ_DEFS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define RSZ_OFF_INPUT_FRAME_BASE 12'h000
`define RSZ_OFF_INPUT_LINE_STRIDE 12'h004
`define RSZ_OFF_OUTPUT_FRAME_BASE 12'h008
`define RSZ_OFF_OUTPUT_LINE_STRIDE 12'h00C
`define RSZ_OFF_HTAP_PAIR_PHASE0 12'h010
`define RSZ_OFF_STATUS 12'h014

// ***************************************************************
// Field layout
// ***************************************************************
`define RSZ_ALIGN_BITS 5
`define RSZ_STRIDE_MSB 15
`define RSZ_ODD_TAP_MSB 25
`define RSZ_ODD_TAP_LSB 16
`define RSZ_EVEN_TAP_MSB 9
`define RSZ_EVEN_TAP_LSB 0
`define RSZ_UNITY_TAP 10'h100

// ***************************************************************
// Reset values
// ***************************************************************
`define RSZ_RESET_WORD 32'h00000000
`define RSZ_RESET_STRIDE 16'h0000
`define RSZ_RESET_TAP 10'h000

`endif

// ### core/rsz_pkg.sv
// Types shared by the resizer stride and coefficient register bank.
// Assumes rsz_defs.svh is on the include path.
package rsz_pkg;
   `include "rsz_defs.svh"
   // Signed 10-bit coefficient, 8 fractional bits
   typedef logic signed [9:0] rsz_tap_t;
   // Line stride in bytes
   typedef logic [15:0] rsz_stride_t;
   // Frame base byte address
   typedef logic [31:0] rsz_addr_t;
endpackage

// ### core/rsz_stride_coef_regs.sv
// Resizer register bank: input frame base, input and output line stride,
// output frame base and the phase-0 horizontal tap pair, over APB.
// Assumes one 250 MHz clock, synchronous active-high reset, and that the
// frame start pulse comes from resizer logic on the same clock.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsz_defs.svh"

module rsz_stride_coef_regs
(
   // Clock, reset and clock enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Resizer core status
   input wire logic busy_in,
   input wire logic frame_start_in,
   // Active values for the frame in progress
   output rsz_pkg::rsz_addr_t in_base_out,
   output rsz_pkg::rsz_stride_t in_stride_out,
   output rsz_pkg::rsz_addr_t out_base_out,
   output rsz_pkg::rsz_stride_t out_stride_out,
   // Phase-0 horizontal taps
   output rsz_pkg::rsz_tap_t odd_tap_weight_out,
   output rsz_pkg::rsz_tap_t even_tap_weight_out
);
   import rsz_pkg::*;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Strobes let software change one byte without reading it first
   // Merge a write word into an old word under byte strobes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Clear the alignment bits of a word
   function automatic logic [31:0] align32(input logic [31:0] w);
      logic [31:0] res;
      res = w;
      res[`RSZ_ALIGN_BITS-1:0] = '0;
      return res;
   endfunction

   // ***************************************************************
   // Register state
   // ***************************************************************
   // Software-visible (pending) values
   rsz_addr_t in_base;
   rsz_stride_t in_stride;
   rsz_addr_t out_base;
   rsz_stride_t out_stride;
   rsz_tap_t odd_tap;
   rsz_tap_t even_tap;
   // Next values
   rsz_addr_t next_in_base;
   rsz_stride_t next_in_stride;
   rsz_addr_t next_out_base;
   rsz_stride_t next_out_stride;
   rsz_tap_t next_odd_tap;
   rsz_tap_t next_even_tap;
   // Bus answer registers
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   // Decoded bus phases
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_word;
   logic hit;

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   // An access is taken in its first access cycle; pready ends it one
   // cycle later, and gating on pready keeps it from being taken twice
   assign wr_go = psel_in & penable_in & pwrite_in & ~pready_out;
   assign rd_go = psel_in & penable_in & ~pwrite_in & ~pready_out;

   // Read mux; reserved bits read zero
   always_comb
   begin
      rd_word = '0;
      hit = 1'b1;
      // Full 12-bit decode: unaligned offsets count as unmapped
      case (paddr_in)
         `RSZ_OFF_INPUT_FRAME_BASE: rd_word = in_base;
         `RSZ_OFF_INPUT_LINE_STRIDE: rd_word = {16'h0000, in_stride};
         `RSZ_OFF_OUTPUT_FRAME_BASE: rd_word = out_base;
         `RSZ_OFF_OUTPUT_LINE_STRIDE: rd_word = {16'h0000, out_stride};
         `RSZ_OFF_HTAP_PAIR_PHASE0:
         begin
            rd_word[`RSZ_ODD_TAP_MSB:`RSZ_ODD_TAP_LSB] = odd_tap;
            rd_word[`RSZ_EVEN_TAP_MSB:`RSZ_EVEN_TAP_LSB] = even_tap;
         end
         // Live busy level, so software sees the state of this cycle
         `RSZ_OFF_STATUS: rd_word = {31'h00000000, busy_in};
         // Unmapped offsets read zero and raise an error
         default: hit = 1'b0;
      endcase
   end

   // ***************************************************************
   // Write decode
   // ***************************************************************
   // Write decode; values stored at once, reads see them at once
   always_comb
   begin
      logic [31:0] m;
      m = '0;
      next_in_base = in_base;
      next_in_stride = in_stride;
      next_out_base = out_base;
      next_out_stride = out_stride;
      next_odd_tap = odd_tap;
      next_even_tap = even_tap;
      // Writes are accepted even while busy; hold-off is in the shadow
      if (wr_go)
      begin
         case (paddr_in)
            `RSZ_OFF_INPUT_FRAME_BASE:
            begin
               m = merge_bytes(in_base, pwdata_in, pstrb_in);
               next_in_base = align32(m);
            end
            `RSZ_OFF_INPUT_LINE_STRIDE:
            begin
               m = merge_bytes({16'h0000, in_stride}, pwdata_in, pstrb_in);
               m = align32(m);
               next_in_stride = m[`RSZ_STRIDE_MSB:0];
            end
            `RSZ_OFF_OUTPUT_FRAME_BASE:
            begin
               // Low bits are kept as written and dropped on use
               next_out_base = merge_bytes(out_base, pwdata_in, pstrb_in);
            end
            `RSZ_OFF_OUTPUT_LINE_STRIDE:
            begin
               m = merge_bytes({16'h0000, out_stride}, pwdata_in, pstrb_in);
               next_out_stride = m[`RSZ_STRIDE_MSB:0];
            end
            `RSZ_OFF_HTAP_PAIR_PHASE0:
            begin
               m = '0;
               m[`RSZ_ODD_TAP_MSB:`RSZ_ODD_TAP_LSB] = odd_tap;
               m[`RSZ_EVEN_TAP_MSB:`RSZ_EVEN_TAP_LSB] = even_tap;
               m = merge_bytes(m, pwdata_in, pstrb_in);
               next_odd_tap = m[`RSZ_ODD_TAP_MSB:`RSZ_ODD_TAP_LSB];
               next_even_tap = m[`RSZ_EVEN_TAP_MSB:`RSZ_EVEN_TAP_LSB];
            end
            default:
            begin
               // Unmapped or status offset: nothing is stored
               m = '0;
            end
         endcase
      end
   end

   // ***************************************************************
   // Bus answer
   // ***************************************************************
   // Bus answer: one wait state, error on unmapped or status write
   always_comb
   begin
      next_pready = wr_go | rd_go;
      next_pslverr = 1'b0;
      // Read data stays until the next read completes
      next_prdata = prdata_out;
      if (rd_go)
      begin
         // Latched once per read, then held for the master
         next_prdata = rd_word;
         next_pslverr = ~hit;
      end
      else if (wr_go)
      begin
         // Status is read-only, so a write to it is refused
         next_pslverr = ~hit | (paddr_in == `RSZ_OFF_STATUS);
      end
   end

   // Register the software-facing state
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         // Every field and the bus answer clear to zero
         in_base <= `RSZ_RESET_WORD;
         in_stride <= `RSZ_RESET_STRIDE;
         out_base <= `RSZ_RESET_WORD;
         out_stride <= `RSZ_RESET_STRIDE;
         odd_tap <= `RSZ_RESET_TAP;
         even_tap <= `RSZ_RESET_TAP;
         prdata_out <= `RSZ_RESET_WORD;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         // Nothing moves while the clock enable is low
         in_base <= next_in_base;
         in_stride <= next_in_stride;
         out_base <= next_out_base;
         out_stride <= next_out_stride;
         odd_tap <= next_odd_tap;
         even_tap <= next_even_tap;
         prdata_out <= next_prdata;
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
      end
   end

   // ***************************************************************
   // Active shadow for the frame in progress
   // ***************************************************************
   // Next values of the active copy
   rsz_addr_t next_in_base_act;
   rsz_stride_t next_in_stride_act;
   rsz_addr_t next_out_base_act;
   rsz_stride_t next_out_stride_act;
   rsz_tap_t next_odd_act;
   rsz_tap_t next_even_act;

   // All fields move in the same cycle so a frame never mixes settings;
   // a write in the boundary cycle itself misses this frame by design
   always_comb
   begin
      next_in_base_act = in_base_out;
      next_in_stride_act = in_stride_out;
      next_out_base_act = out_base_out;
      next_out_stride_act = out_stride_out;
      next_odd_act = odd_tap_weight_out;
      next_even_act = even_tap_weight_out;
      if (frame_start_in)
      begin
         // Output alignment applied here so reads keep what was written
         next_in_base_act = in_base;
         next_in_stride_act = in_stride;
         next_out_base_act = align32(out_base);
         next_out_stride_act = {out_stride[`RSZ_STRIDE_MSB:`RSZ_ALIGN_BITS],
                                5'h00};
         next_odd_act = odd_tap;
         next_even_act = even_tap;
      end
   end

   // Register the active values
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         // Active values clear to zero with the rest
         in_base_out <= `RSZ_RESET_WORD;
         in_stride_out <= `RSZ_RESET_STRIDE;
         out_base_out <= `RSZ_RESET_WORD;
         out_stride_out <= `RSZ_RESET_STRIDE;
         odd_tap_weight_out <= `RSZ_RESET_TAP;
         even_tap_weight_out <= `RSZ_RESET_TAP;
      end
      else if (clk_en_in)
      begin
         // A boundary pulse seen while frozen is not acted on
         in_base_out <= next_in_base_act;
         in_stride_out <= next_in_stride_act;
         out_base_out <= next_out_base_act;
         out_stride_out <= next_out_stride_act;
         odd_tap_weight_out <= next_odd_act;
         even_tap_weight_out <= next_even_act;
      end
   end

endmodule
`default_nettype wire

// ### verif/rsz_regs_monitor.sv
// Checker for the stride and tap register bank, bound to its top ports.
// Assumes clk_en_in stays high whenever a bus transfer is under way.
`timescale 1ns/1ps
`default_nettype none
module rsz_regs_monitor
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Register bus
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Frame boundary and active values
   input wire logic frame_start_in,
   input wire rsz_pkg::rsz_addr_t in_base_out,
   input wire rsz_pkg::rsz_stride_t in_stride_out,
   input wire rsz_pkg::rsz_addr_t out_base_out,
   input wire rsz_pkg::rsz_stride_t out_stride_out
);
   import rsz_pkg::*;
   // ****************************************
   // Properties
   // ****************************************
   // Read completing this cycle
   wire logic rd_ok = pready_out && !pwrite_in;
   // Active base and stride values (not the taps), so one check covers a mixed update
   wire logic [95:0] act = {in_base_out, in_stride_out, out_base_out,
      out_stride_out};
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   ready_wait_a: assert property (psel_in && penable_in && !pready_out
      |=> pready_out) else $error("ready late");
   ready_once_a: assert property (pready_out |=> !pready_out)
      else $error("ready held too long");
   ready_cause_a: assert property (pready_out |-> $past(penable_in))
      else $error("ready without access");
   frame_hold_a: assert property (!frame_start_in |=> $stable(act))
      else $error("active value moved inside a frame");
   out_align_a: assert property (out_base_out[4:0] == 5'h00
      && out_stride_out[4:0] == 5'h00) else $error("output low bits set");
   in_align_a: assert property (in_base_out[4:0] == 5'h00
      && in_stride_out[4:0] == 5'h00) else $error("input low bits set");
   stride_rsvd_a: assert property (rd_ok && paddr_in == 12'h004 |->
      prdata_out[31:16] == 16'h0000 && prdata_out[4:0] == 5'h00)
      else $error("stride read bits");
   tap_rsvd_a: assert property (rd_ok && paddr_in == 12'h010 |->
      prdata_out[31:26] == 6'h00 && prdata_out[15:10] == 6'h00)
      else $error("tap read bits");
   unmapped_err_a: assert property (pready_out && (paddr_in > 12'h014
      || paddr_in[1:0] != 2'h0) |->
      pslverr_out && (pwrite_in || prdata_out == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready_out && paddr_in < 12'h014
      && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
      else $error("mapped access refused");
   frame_c: cover property (frame_start_in);
   err_c: cover property (pready_out && pslverr_out);
   tap_rd_c: cover property (rd_ok && paddr_in == 12'h010);
endmodule
bind rsz_stride_coef_regs rsz_regs_monitor mon (.*);
`default_nettype wire

// ### verif/rsz_stride_coef_regs_tb.sv
// Bench for the register bank: drives the bus and frame inputs by hand.
// Assumes the bank and its bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module rsz_stride_coef_regs_tb;
   import rsz_pkg::*;
   // Stimulus, changed only just after rising edges
   logic clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
   logic pwrite_in = 1'b0, busy_in = 1'b0, frame_start_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] pstrb_in = 4'hF;
   // Observed outputs
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out;
   rsz_addr_t in_base_out, out_base_out;
   rsz_stride_t in_stride_out, out_stride_out;
   rsz_tap_t odd_tap_weight_out, even_tap_weight_out;
   int fails = 0, check_count = 0;
   // Read-back after all-ones writes: reserved bits and input low bits cleared, output low bits kept
   logic [31:0] msk [5] = '{32'hFFFFFFE0, 32'h0000FFE0, 32'hFFFFFFFF,
      32'h0000FFFF, 32'h03FF03FF};
   always #2 clk_in = ~clk_in;
   // Clock enable stays high except in the freeze scenario
   rsz_stride_coef_regs uut (.clk_in, .reset_in, .clk_en_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
      .prdata_out, .pready_out, .pslverr_out, .busy_in, .frame_start_in,
      .in_base_out, .in_stride_out, .out_base_out, .out_stride_out,
      .odd_tap_weight_out, .even_tap_weight_out);
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // One bus transfer; waits for ready under a bound
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] x, input logic xe);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 50);
      chk({31'h0, pslverr_out}, {31'h0, xe});
      if (!w)
         chk(prdata_out, x);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (pready_out !== 1'b1)
      begin
         fails++;
         $display("Error at %0t: no ready from the bank", $time);
         give_verdict();
      end
   endtask
   // Frame boundary pulse, then one cycle for outputs to land
   task automatic frame;
      @(posedge clk_in);
      frame_start_in <= 1'b1;
      @(posedge clk_in);
      frame_start_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic outs(input logic [31:0] ib, si, ob, so, od, ev);
      chk(in_base_out, ib);
      chk({16'h0, in_stride_out}, si);
      chk(out_base_out, ob);
      chk({16'h0, out_stride_out}, so);
      chk({22'h0, odd_tap_weight_out}, od);
      chk({22'h0, even_tap_weight_out}, ev);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_masks;
      busy_in <= 1'b1;
      for (int i = 0; i < 5; i++)
         xfer(1'b1, 12'(4 * i), 32'hFFFFFFFF, 32'h0, 1'b0);
      for (int i = 0; i < 5; i++)
         xfer(1'b0, 12'(4 * i), 32'h0, msk[i], 1'b0);
      outs(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
      frame();
      outs(32'hFFFFFFE0, 32'hFFE0, 32'hFFFFFFE0, 32'hFFE0, 32'h3FF,
         32'h3FF);
   endtask
   // Writes while busy stay pending until the next frame
   task automatic t_busy;
      xfer(1'b1, 12'h000, 32'h10000040, 32'h0, 1'b0);
      xfer(1'b1, 12'h004, 32'h00000840, 32'h0, 1'b0);
      xfer(1'b1, 12'h008, 32'h20000060, 32'h0, 1'b0);
      xfer(1'b1, 12'h00C, 32'h00000960, 32'h0, 1'b0);
      xfer(1'b1, 12'h010, 32'h01000100, 32'h0, 1'b0);
      xfer(1'b0, 12'h008, 32'h0, 32'h20000060, 1'b0);
      outs(32'hFFFFFFE0, 32'hFFE0, 32'hFFFFFFE0, 32'hFFE0, 32'h3FF,
         32'h3FF);
      frame();
      outs(32'h10000040, 32'h840, 32'h20000060, 32'h960, 32'h100,
         32'h100);
      pstrb_in <= 4'h1;
      xfer(1'b1, 12'h004, 32'h0000FFFF, 32'h0, 1'b0);
      pstrb_in <= 4'hF;
      xfer(1'b0, 12'h004, 32'h0, 32'h000008E0, 1'b0);
   endtask
   // Status read, refused accesses, input frame base undisturbed by them
   task automatic t_err;
      xfer(1'b0, 12'h014, 32'h0, 32'h00000001, 1'b0);
      xfer(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, 12'h014, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, 12'hFFC, 32'h0, 32'h0, 1'b1);
      xfer(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
      busy_in <= 1'b0;
      xfer(1'b0, 12'h014, 32'h0, 32'h00000000, 1'b0);
      xfer(1'b0, 12'h000, 32'h0, 32'h10000040, 1'b0);
   endtask
   // Clock enable low swallows a boundary pulse; a zero input stride
   // is then written and taken over at the next frame
   task automatic t_freeze;
      @(posedge clk_in);
      clk_en_in <= 1'b0;
      frame_start_in <= 1'b1;
      @(posedge clk_in);
      clk_en_in <= 1'b1;
      frame_start_in <= 1'b0;
      @(posedge clk_in);
      chk({16'h0, in_stride_out}, 32'h00000840);
      frame();
      chk({16'h0, in_stride_out}, 32'h000008E0);
      xfer(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
      frame();
      chk({16'h0, in_stride_out}, 32'h0);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 5; i++)
         xfer(1'b0, 12'(4 * i), 32'h0, 32'h0, 1'b0);
      outs(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
      t_masks();
      t_busy();
      t_err();
      t_freeze();
      give_verdict();
   end
endmodule
`default_nettype wire
